// file: crs_cfg.svh
/*
 * Constants for the completion receive stream framer: field positions in the
 * sideband bus, descriptor field positions, register offsets and reset values.
 * Assumes nothing; included by crs_pkg, the framer, the checker and the bench.
 */
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// Sideband bus layout
`define CRS_SB_BYTE_EN_LSB 0
`define CRS_SB_SOP_LSB 64
`define CRS_SB_EOP_LSB 68
`define CRS_SB_DISC_BIT 96
`define CRS_SB_WIDTH 97

// Descriptor fields used for placement
`define CRS_DESC_LADDR_LSB 0
`define CRS_DESC_BCNT_LSB 16
`define CRS_DESC_DWCNT_LSB 32
`define CRS_DESC_DWORDS 3

// Register offsets (byte addresses)
`define CRS_REG_CTRL 12'h000
`define CRS_REG_STATUS 12'h004
`define CRS_REG_COUNT 12'h008

// Control fields and reset value
`define CRS_CTRL_ALIGN_BIT 0
`define CRS_CTRL_STRADDLE_BIT 1
`define CRS_CTRL_RESET 32'h0000_0000

// Slave answers
`define CRS_RESP_OKAY 2'b00
`define CRS_RESP_SLVERR 2'b10

`endif

// file: crs_pkg.sv
/*
 * Types for the completion receive stream framer.
 * Assumes crs_cfg.svh is on the include path.
 */
`include "crs_cfg.svh"

package crs_pkg;

    // Completion as handed over by the core side, one at a time
    typedef struct packed {
        logic [95:0] desc;
        logic [10:0] dword_count;
        logic [1:0] align_hint;
        logic [3:0] first_be;
        logic [3:0] last_be;
        logic zero_len;
        logic mem_error;
    } crs_cpl_hdr_t;

    // One beat of the completion stream
    typedef struct packed {
        logic [511:0] data;
        logic [15:0] keep;
        logic last;
        logic [`CRS_SB_WIDTH-1:0] sideband;
    } crs_beat_t;

    typedef enum logic [1:0] {
        CRS_IDLE,
        CRS_DESC,
        CRS_PAYLOAD
    } crs_state_t;

endpackage

// file: crs_framer.sv
/*
 * Completion receive stream framer: turns one completion header plus a
 * stream of payload dwords into 512-bit stream beats with keep, last,
 * start-of-packet, byte-lane valid and discontinue signalling. Registers
 * sit on an AXI4-Lite slave.
 * Assumes one clock, synchronous active-low reset, payload dwords offered
 * sixteen at a time on pay_* and a receiver that obeys valid/accept.
 */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "crs_cfg.svh"

module crs_framer #(
    parameter int MAX_DWORDS = 1024
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Completion header from the core side
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire crs_pkg::crs_cpl_hdr_t hdr,
    // Payload dwords, sixteen per word, lowest dword first
    input wire logic pay_valid,
    output logic pay_ready,
    input wire logic [511:0] pay_data,
    // Completion stream to user logic
    output logic completion_beat_valid,
    input wire logic completion_beat_accept,
    output logic [511:0] completion_data_bus,
    output logic [15:0] completion_dword_keep,
    output logic completion_packet_end,
    output logic [`CRS_SB_WIDTH-1:0] completion_sideband_bus,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import crs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    logic [31:0] ctrl;
    logic [31:0] pkt_count;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    crs_state_t state;

    // Address and data taken in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (s_axi_bvalid && s_axi_bready) begin
                w_held <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    // Write response and control update; mode only changes between packets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CRS_RESP_OKAY;
            ctrl <= `CRS_CTRL_RESET;
        end else if (aw_held && w_held && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `CRS_RESP_OKAY;
            if (aw_addr[11:2] == `CRS_REG_CTRL >> 2) begin
                if (w_strb[0] && state == CRS_IDLE) begin
                    ctrl[`CRS_CTRL_ALIGN_BIT] <= w_data[`CRS_CTRL_ALIGN_BIT];
                    // Straddle kept off while aligned mode is selected
                    ctrl[`CRS_CTRL_STRADDLE_BIT] <= w_data[`CRS_CTRL_STRADDLE_BIT]
                        && !w_data[`CRS_CTRL_ALIGN_BIT];
                end
            end else if (aw_addr[11:2] != `CRS_REG_STATUS >> 2
                         && aw_addr[11:2] != `CRS_REG_COUNT >> 2) begin
                s_axi_bresp <= `CRS_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel, one cycle to answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CRS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CRS_RESP_OKAY;
            case (s_axi_araddr[11:2])
                `CRS_REG_CTRL >> 2: s_axi_rdata <= {30'h0, ctrl[1:0]};
                `CRS_REG_STATUS >> 2: s_axi_rdata <= {30'h0, state == CRS_PAYLOAD,
                                                       state != CRS_IDLE};
                `CRS_REG_COUNT >> 2: s_axi_rdata <= pkt_count;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `CRS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Framing state
    logic aligned;
    logic [11:0] dw_left;
    logic [4:0] lead;
    logic [3:0] first_be;
    logic [3:0] last_be;
    logic zero_len;
    logic mem_error;
    logic [511:0] carry;
    logic [4:0] carry_n;
    logic take_beat;
    logic beat_free;

    assign aligned = ctrl[`CRS_CTRL_ALIGN_BIT];
    // A beat moves only when both sides agree
    assign take_beat = completion_beat_valid && completion_beat_accept;
    // Output register may load when empty or being drained
    assign beat_free = !completion_beat_valid || completion_beat_accept;
    assign hdr_ready = state == CRS_IDLE && beat_free;

    // Dwords that can go into the current beat and whether input is needed
    logic [4:0] room;
    logic [4:0] fill;
    logic need_pay;
    logic beat_last;
    logic [4:0] new_carry;
    always_comb begin
        room = 5'd16 - lead;
        fill = (dw_left > 12'(room)) ? room : dw_left[4:0];
        need_pay = state == CRS_PAYLOAD && fill > carry_n && beat_free;
        beat_last = dw_left <= 12'(room);
        new_carry = need_pay ? 5'(carry_n + 5'd16 - fill) : 5'(carry_n - fill);
    end
    assign pay_ready = need_pay && !beat_last ? 1'b1 : need_pay;

    // Header capture and payload walk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= CRS_IDLE;
            dw_left <= 12'h000;
            lead <= 5'd0;
            first_be <= 4'h0;
            last_be <= 4'h0;
            zero_len <= 1'b0;
            mem_error <= 1'b0;
            carry_n <= 5'd0;
        end else begin
            case (state)
                CRS_IDLE: begin
                    if (hdr_valid && hdr_ready) begin
                        // Zero-length read still carries one dword
                        dw_left <= hdr.zero_len ? 12'h001 : {1'b0, hdr.dword_count};
                        first_be <= hdr.first_be;
                        last_be <= hdr.last_be;
                        zero_len <= hdr.zero_len;
                        mem_error <= hdr.mem_error;
                        carry_n <= 5'd0;
                        if (aligned) begin
                            // Payload waits for the next beat, offset by four dwords plus the hint
                            lead <= {1'b0, 2'b01, hdr.align_hint};
                            state <= CRS_DESC;
                        end else begin
                            // Payload follows descriptor dwords directly
                            lead <= 5'd`CRS_DESC_DWORDS;
                            state <= (hdr.dword_count == 11'h0 && !hdr.zero_len)
                                ? CRS_DESC : CRS_PAYLOAD;
                        end
                    end
                end
                CRS_DESC: begin
                    if (take_beat) begin
                        state <= (dw_left == 12'h000) ? CRS_IDLE : CRS_PAYLOAD;
                    end
                end
                CRS_PAYLOAD: begin
                    if (beat_free && (carry_n >= fill || pay_valid)) begin
                        carry_n <= new_carry;
                        dw_left <= dw_left - 12'(fill);
                        lead <= 5'd0;
                        if (beat_last) begin
                            state <= CRS_IDLE;
                        end
                    end
                end
                default: state <= CRS_IDLE;
            endcase
        end
    end

    // Leftover payload dwords kept for the next beat
    logic [1023:0] pool;
    always_comb begin
        pool = {512'h0, carry};
        if (need_pay) begin
            pool = pool | ({512'h0, pay_data} << (32 * carry_n));
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry <= 512'h0;
        end else if (state == CRS_IDLE) begin
            // Padding of a packet's last word must not leak into the next packet
            carry <= 512'h0;
        end else if (state == CRS_PAYLOAD && beat_free && (carry_n >= fill || pay_valid)) begin
            carry <= 512'(pool >> (32 * fill));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output beat
    logic [15:0] keep_mask;
    logic [63:0] lane_en;
    always_comb begin
        keep_mask = 16'hFFFF;
        lane_en = 64'h0;
        for (int i = 0; i < 16; i++) begin
            // Keep clears only past the packet's final dword
            if (beat_last && i >= lead + fill) begin
                keep_mask[i] = 1'b0;
            end
            // Byte lanes only where payload dwords sit
            if (i >= lead && i < lead + fill && !zero_len) begin
                lane_en[4*i +: 4] = 4'hF;
            end
        end
        // Edge dwords trimmed by the first and last byte enables
        if (!zero_len) begin
            // Only the first payload beat has a lead; later beats start at dword 0
            if (lead != 5'd0) begin
                lane_en[4*lead +: 4] = lane_en[4*lead +: 4] & first_be;
            end
            // Last dword trimmed unless it is also the first one
            if (beat_last && fill != 5'd0 && (lead == 5'd0 || fill > 5'd1)) begin
                lane_en[4*(lead+fill-1) +: 4] = lane_en[4*(lead+fill-1) +: 4] & last_be;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            completion_beat_valid <= 1'b0;
            completion_data_bus <= 512'h0;
            completion_dword_keep <= 16'h0000;
            completion_packet_end <= 1'b0;
            completion_sideband_bus <= '0;
            pkt_count <= 32'h0000_0000;
        end else begin
            if (take_beat && completion_packet_end) begin
                pkt_count <= pkt_count + 32'h0000_0001;
            end
            if (state == CRS_IDLE && hdr_valid && hdr_ready) begin
                // Descriptor beat opens the packet
                completion_beat_valid <= 1'b1;
                completion_data_bus <= {416'h0, hdr.desc};
                completion_sideband_bus <= '0;
                completion_sideband_bus[`CRS_SB_SOP_LSB] <= 1'b1;
                if (aligned || (hdr.dword_count == 11'h0 && !hdr.zero_len)) begin
                    // Aligned: null dwords after the descriptor are kept as well
                    completion_dword_keep <= aligned ? 16'hFFFF : 16'h0007;
                    completion_packet_end <= !aligned;
                end else begin
                    // Held back: payload joins this beat in the cycle its first word is taken
                    completion_beat_valid <= 1'b0;
                end
            end else if (state == CRS_PAYLOAD && beat_free
                         && (carry_n >= fill || pay_valid)) begin
                completion_beat_valid <= 1'b1;
                for (int i = 0; i < 16; i++) begin
                    if (i >= lead) begin
                        completion_data_bus[32*i +: 32] <= pool[32*(i-lead) +: 32];
                    end
                end
                completion_dword_keep <= keep_mask;
                completion_packet_end <= beat_last;
                completion_sideband_bus[63:0] <= lane_en;
                completion_sideband_bus[`CRS_SB_SOP_LSB] <= lead == 5'd`CRS_DESC_DWORDS;
                completion_sideband_bus[`CRS_SB_DISC_BIT] <= beat_last && mem_error;
            end else if (take_beat) begin
                completion_beat_valid <= 1'b0;
            end
        end
    end

endmodule

// file: crs_framer_chk.sv
/* Checker of the framer's stream and read ports.
   Assumes a bind onto crs_framer; sees its ports only. */
`timescale 1ns/1ps
`include "crs_cfg.svh"
module crs_framer_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Stream
    input wire logic completion_beat_valid,
    input wire logic completion_beat_accept,
    input wire logic [511:0] completion_data_bus,
    input wire logic [15:0] completion_dword_keep,
    input wire logic completion_packet_end,
    input wire logic [`CRS_SB_WIDTH-1:0] completion_sideband_bus,
    // Read channel
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    wire logic v = completion_beat_valid;
    wire logic lst = completion_packet_end;
    wire logic [15:0] kp = completion_dword_keep;
    wire logic [`CRS_SB_WIDTH-1:0] sb = completion_sideband_bus;
    logic in_pkt;
    logic [15:0] lane_dw;
    // Packet open after its first beat moved
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_pkt <= 1'b0;
        end else if (v && completion_beat_accept) begin
            in_pkt <= !lst;
        end
    end
    // Dwords carrying any byte-lane bit
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            lane_dw[i] = |sb[4*i +: 4];
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_hold;
        v && !completion_beat_accept |=> v && $stable(completion_data_bus) && $stable(kp)
            && $stable(lst) && $stable(sb);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled beat changed");
    property p_full; v && !lst |-> kp == 16'hFFFF; endproperty
    a_full: assert property (p_full) else $error("keep gap before end");
    property p_contig; v |-> kp[0] && ((kp + 16'h0001) & kp) == 16'h0000; endproperty
    a_contig: assert property (p_contig) else $error("keep not contiguous");
    property p_sop; v && !in_pkt |-> sb[64]; endproperty
    a_sop: assert property (p_sop) else $error("first beat lacks start");
    property p_mid; v && in_pkt |-> !sb[64]; endproperty
    a_mid: assert property (p_mid) else $error("start inside packet");
    property p_rest; v |-> sb[95:65] == 31'h0000_0000; endproperty
    a_rest: assert property (p_rest) else $error("other marks set");
    property p_disc; v && sb[96] |-> lst; endproperty
    a_disc: assert property (p_disc) else $error("discontinue not on end");
    property p_lanes; v |-> (lane_dw & ~kp) == 16'h0000; endproperty
    a_lanes: assert property (p_lanes) else $error("lane outside kept dword");
    property p_desc; v && sb[64] |-> sb[11:0] == 12'h000; endproperty
    a_desc: assert property (p_desc) else $error("lane on descriptor");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    c_stall: cover property (v && !completion_beat_accept);
    c_end: cover property (v && completion_beat_accept && lst);
    c_disc: cover property (v && sb[96]);
endmodule
bind crs_framer crs_framer_chk crs_framer_chk_inst (.*);

// file: crs_sink.sv
/* Receiving user logic: takes beats, stalling on a random bit.
   Assumes the bench hands it a fresh bit each cycle. */
`timescale 1ns/1ps
module crs_sink (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Stall pattern
    input wire logic take_bit,
    // Stream handshake
    output logic completion_beat_accept
);
    // Free to drop accept at any beat; the framer must hold it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            completion_beat_accept <= 1'b0;
        end else begin
            completion_beat_accept <= take_bit;
        end
    end
endmodule

// file: completion_rx_stream_tb.sv
/* Bench: queue model of the beats, stalling sink, register access.
   Assumes crs_pkg, crs_framer, crs_sink and the checker compiled. */
`timescale 1ns/1ps
`include "crs_cfg.svh"
module completion_rx_stream_tb;
    import crs_pkg::*;
    logic aclk, aresetn, hdr_valid, hdr_ready, pay_valid, pay_ready, cv, ca, cl, tk, stall;
    crs_cpl_hdr_t hdr;
    logic [511:0] pay_data, cd;
    logic [15:0] ck, m;
    logic [`CRS_SB_WIDTH-1:0] sb;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    crs_beat_t exp_q[$];
    crs_beat_t eb;
    logic [15:0] cmp_q[$];
    logic [511:0] pay_q[$];
    int failures, n_compared, nsent;
    int lens[5] = '{2, 13, 14, 29, 45};
    logic [31:0] seed = 32'h0044_7799;
    crs_framer crs_framer_inst (.aclk(aclk), .aresetn(aresetn), .hdr_valid(hdr_valid),
        .hdr_ready(hdr_ready), .hdr(hdr), .pay_valid(pay_valid), .pay_ready(pay_ready),
        .pay_data(pay_data), .completion_beat_valid(cv), .completion_beat_accept(ca),
        .completion_data_bus(cd), .completion_dword_keep(ck), .completion_packet_end(cl),
        .completion_sideband_bus(sb), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    crs_sink crs_sink_inst (.aclk(aclk), .aresetn(aresetn), .take_bit(tk),
        .completion_beat_accept(ca));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [511:0] seen, input logic [511:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Register bus master; ends one edge later so strobes never re-toggle
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(bresp, er);
        @(posedge aclk);
    endtask
    task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        check({rresp, rdata}, {er, d});
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Offer one completion's header, then model it into expected beats
    task automatic send(input int n, input bit al, input int hint, input bit zl, input bit me);
        int off, tot, d;
        logic [3:0] fbe, lbe;
        logic [31:0] pd[$];
        logic [511:0] w;
        crs_beat_t b;
        off = al ? 20 + hint : 3;
        tot = off + n;
        fbe = 4'hF << (rnd() % 4);
        lbe = 4'hF >> (rnd() % 4);
        hdr <= '{desc: {rnd(), rnd(), rnd()}, dword_count: 11'(n), align_hint: 2'(hint),
            first_be: fbe, last_be: lbe, zero_len: zl, mem_error: me};
        hdr_valid <= 1'b1;
        for (int k = 0; k < (n + 15) / 16; k++) begin
            for (int i = 0; i < 16; i++) begin
                w[32*i +: 32] = rnd();
                pd.push_back(w[32*i +: 32]);
            end
            pay_q.push_back(w);
        end
        #1;
        for (int bt = 0; bt < (tot + 15) / 16; bt++) begin
            b = '0;
            m = '0;
            for (int p = 0; p < 16; p++) begin
                d = bt * 16 + p;
                b.keep[p] = d < tot;
                if (d < 3) begin
                    b.data[32*p +: 32] = hdr.desc[32*d +: 32];
                    m[p] = 1'b1;
                end else if (d >= off && d < tot) begin
                    b.data[32*p +: 32] = pd[d-off];
                    m[p] = !zl;
                    // Kept request enables mark short payloads
                    b.sideband[4*p +: 4] = zl ? 4'h0 : d == off ? fbe :
                        d == tot - 1 ? lbe : 4'hF;
                end
            end
            b.last = bt == (tot + 15) / 16 - 1;
            b.sideband[64] = bt == 0;
            b.sideband[96] = me && b.last;
            exp_q.push_back(b);
            cmp_q.push_back(m);
        end
        nsent++;
        do @(posedge aclk); while (hdr_ready !== 1'b1);
        hdr_valid <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic drain();
        while (exp_q.size() > 0) @(posedge aclk);
        repeat (4) @(posedge aclk);
        pay_q.delete();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Payload source; idle data is inverted so stale words never match
    always @(posedge aclk) begin
        if (pay_valid && pay_ready) void'(pay_q.pop_front());
        pay_valid <= pay_q.size() > 0;
        pay_data <= pay_q.size() > 0 ? pay_q[0] : ~pay_data;
        tk <= stall ? ^rnd() : 1'b1;
    end
    // Every accepted beat against the model
    always @(posedge aclk) begin
        if (aresetn && cv && ca) begin
            if (exp_q.size() == 0) check(1, 0);
            else begin
                eb = exp_q.pop_front();
                m = cmp_q.pop_front();
                check({ck, cl}, {eb.keep, eb.last});
                check(sb, eb.sideband);
                for (int i = 0; i < 16; i++) begin
                    if (m[i]) check(cd[32*i +: 32], eb.data[32*i +: 32]);
                end
            end
        end
    end
    initial begin
        #400_000;
        failures++;
        complete_run();
    end
    initial begin
        {hdr_valid, pay_valid, awvalid, wvalid, bready, arvalid, rready, stall, tk} = '0;
        hdr = '0;
        pay_data = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        check({pay_ready, cv, cl, ck, bvalid, rvalid, hdr_ready, arready, awready, wready},
            25'h000_000F);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(`CRS_REG_CTRL, `CRS_CTRL_RESET, `CRS_RESP_OKAY);
        stall <= 1'b1;
        foreach (lens[i]) send(lens[i], 0, 0, 0, i == 3);
        send(1, 0, 0, 1, 0);
        send(0, 0, 0, 0, 0);
        drain();
        axw(`CRS_REG_CTRL, 32'h0000_0003, `CRS_RESP_OKAY);
        axr(`CRS_REG_CTRL, 32'h0000_0001, `CRS_RESP_OKAY);
        for (int h = 0; h < 4; h++) send(rnd() % 40 + 2, 1, h, 0, h == 2);
        drain();
        axr(`CRS_REG_COUNT, 32'(nsent), `CRS_RESP_OKAY);
        axr(`CRS_REG_STATUS, 32'h0000_0000, `CRS_RESP_OKAY);
        axr(12'h010, 32'h0000_0000, `CRS_RESP_SLVERR);
        axw(12'h010, 32'h0000_0005, `CRS_RESP_SLVERR);
        complete_run();
    end
endmodule
